// File: sysctl.sv
// Reset sources, watchdog, interrupt option register, flag-set and return stack control.
// Assumes an AHB-Lite master, a core that reports instructions and interrupt/return steps.
//
// What this block does
// - Five causes reset the device.
// - Internal reset is copy of any cause, stretched by STRETCH_CYCLES.
// - Pin low in run: halt, pull-ups, restart.
// - Pin low in stop: oscillator, pull-ups.
// - Power-on holds reset, then stabilisation delay.
// - Arm bit forced by option, sticky otherwise.
// - Unarmed counter is free 7-bit timer.
// - Clearing soft reset bit resets when armed.
// - Counter bits stored in reversed order.
// - Watchdog register resets to 0xfe.
// - No watchdog timeout reset before 28 instructions.
// - Interrupt entry: flags, push, inhibit, vector.
// - Return restores flags and pops PC.
// - Maskable interrupt in first 3 cycles of clearing load keeps normal flags.
// - Option register write-only, cleared on reset.
// - Bit 6 selects level mode of source 1.
// - Bit 5 selects polarity of source 2.
// - Bit 4 enables all but NMI.
// - Disabled NMI still serviced, no wake.
// - Fixed source to vector mapping.
// - Core starts in NMI flag set.
// - Six 12-bit stack levels, saturating.
`timescale 1ns/1ps
module sysctl #(
  parameter int         STRETCH_CYCLES = 4096,
  parameter logic       HW_WDOG_OPTION = 1'b0,
  parameter int         PC_WIDTH_P     = 12,
  parameter logic [PC_WIDTH_P-1:0] VECTOR_BASE = 12'hff0
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_reset,
  input  wire logic                   i_hsel,
  input  wire logic [31:0]            i_haddr,
  input  wire logic [1:0]             i_htrans,
  input  wire logic                   i_hwrite,
  input  wire logic [2:0]             i_hsize,
  input  wire logic [31:0]            i_hwdata,
  input  wire logic                   i_hready,
  output logic      [31:0]            o_hrdata,
  output logic                        o_hreadyout,
  output logic                        o_hresp,
  input  wire logic                   i_reset_pin_n,
  input  wire logic                   i_power_on,
  input  wire logic                   i_low_voltage_detect,
  input  wire logic                   i_stop_mode,
  input  wire logic                   i_wait_mode,
  input  wire logic                   i_instr_done,
  input  wire logic                   i_ldi_clear_ior,
  input  wire logic                   i_nmi_n,
  input  wire logic                   i_port_a_irq,
  input  wire logic                   i_port_b_irq,
  input  wire logic                   i_timer_zero_flag,
  input  wire logic                   i_timer_irq_mask,
  input  wire logic                   i_adc_done_flag,
  input  wire logic                   i_adc_irq_mask,
  input  wire logic                   i_irq_taken,
  input  wire logic                   i_return_from_interrupt,
  input  wire logic [PC_WIDTH_P-1:0]  i_pc,
  output logic                        o_reset,
  output logic                        o_io_pullup_inputs,
  output logic                        o_osc_restart,
  output logic                        o_irq_request,
  output logic      [PC_WIDTH_P-1:0]  o_vector_pc,
  output logic      [PC_WIDTH_P-1:0]  o_return_pc,
  output logic                        o_wake,
  output logic      [1:0]             o_flag_set
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree

  logic [2:0] pin_sync;
  logic [2:0] nmi_sync;
  logic [2:0] pa_sync;
  logic [2:0] pb_sync;
  logic       pin_low;
  logic       nmi_low;
  logic       pa_lvl;
  logic       pb_lvl;

  always_ff @(posedge i_mclk) begin
    pin_sync <= {pin_sync[1:0], i_reset_pin_n};
    nmi_sync <= {nmi_sync[1:0], i_nmi_n};
    pa_sync  <= {pa_sync[1:0], i_port_a_irq};
    pb_sync  <= {pb_sync[1:0], i_port_b_irq};
  end

  always_ff @(posedge i_mclk) begin
    if (pin_sync[1] == pin_sync[2]) pin_low <= !pin_sync[2];
    if (nmi_sync[1] == nmi_sync[2]) nmi_low <= !nmi_sync[2];
    if (pa_sync[1] == pa_sync[2]) pa_lvl <= pa_sync[2];
    if (pb_sync[1] == pb_sync[2]) pb_lvl <= pb_sync[2];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset causes and stretch

  logic wdog_fire;
  logic int_reset;
  wire  reset_cause = i_reset || pin_low || i_power_on || i_low_voltage_detect
                      || wdog_fire;

  reset_stretch #(
    .STRETCH_CYCLES (STRETCH_CYCLES)
  ) u_stretch (
    .i_mclk  (i_mclk),
    .i_cause (reset_cause),
    .o_reset (int_reset)
  );

  // Pins are held in their safe state for the whole reset; oscillator restart only while the pin is low or power-on
  always_ff @(posedge i_mclk) begin
    o_reset            <= int_reset;
    o_io_pullup_inputs <= int_reset;
    o_osc_restart      <= pin_low || i_power_on;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY

  sysctl_pkg::bus_req_s req;
  logic                 req_valid;
  wire  take      = i_hsel && i_hready && i_htrans[1];
  wire  wr_ior    = req_valid && req.hwrite && req.haddr == sysctl_pkg::ADDR_IRQ_OPTION;
  wire  wr_wdog   = req_valid && req.hwrite && req.haddr == sysctl_pkg::ADDR_WDOG;
  wire  rd_cycle  = take && !i_hwrite;

  always_ff @(posedge i_mclk) begin
    if (int_reset) begin
      req_valid <= 1'b0;
      req       <= '0;
    end else begin
      req_valid <= take;
      req       <= '{htrans1: i_htrans[1], hwrite: i_hwrite, haddr: i_haddr[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt option register: write-only, whole-byte writes only

  logic [7:0] irq_config_register;
  wire        source1_level_mode = irq_config_register[sysctl_pkg::BIT_SRC1_LEVEL];
  wire        source2_polarity   = irq_config_register[sysctl_pkg::BIT_SRC2_POL];
  wire        interrupts_allowed = irq_config_register[sysctl_pkg::BIT_GLOBAL_EN];

  always_ff @(posedge i_mclk) begin
    if (int_reset) irq_config_register <= sysctl_pkg::IRQ_OPTION_RESET;
    else if (wr_ior) irq_config_register <= i_hwdata[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: physical 7-bit downcounter, register view has reversed bits

  logic [6:0] wdog_count;      // [6] is the soft_reset_n bit
  logic       wdog_armed;
  logic [1:0] instr_cnt;
  logic [6:0] since_arm;
  wire  [7:0] watchdog_register;
  wire  [5:0] wdog_count_bits = wdog_count[5:0];
  wire        step = i_instr_done;
  wire        soft_reset_n = wdog_count[6];

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_rev
      assign watchdog_register[7 - gi] = wdog_count_bits[gi];
    end
  endgenerate
  assign watchdog_register[sysctl_pkg::BIT_SOFT_RESET_N] = soft_reset_n;
  assign watchdog_register[sysctl_pkg::BIT_ARM]          = wdog_armed;

  // Written counter bits, put back into physical order
  logic [6:0] wr_count;
  always_comb begin
    wr_count = '0;
    for (int k = 0; k < 6; k++) wr_count[k] = i_hwdata[7 - k];
    wr_count[6] = i_hwdata[sysctl_pkg::BIT_SOFT_RESET_N];
  end

  wire soft_kill = wr_wdog && (wdog_armed || i_hwdata[sysctl_pkg::BIT_ARM])
                   && !i_hwdata[sysctl_pkg::BIT_SOFT_RESET_N];
  wire timeout   = wdog_armed && step && wdog_count == 7'h00
                   && since_arm >= sysctl_pkg::WDOG_MIN_COUNT;

  always_ff @(posedge i_mclk) begin
    if (int_reset) begin
      wdog_count <= sysctl_pkg::WDOG_RESET[7:1];
      wdog_armed <= HW_WDOG_OPTION;
      since_arm  <= '0;
      wdog_fire  <= 1'b0;
    end else begin
      wdog_fire <= soft_kill || timeout;
      if (wr_wdog) begin
        wdog_count <= wr_count;
        wdog_armed <= HW_WDOG_OPTION || wdog_armed || i_hwdata[sysctl_pkg::BIT_ARM];
        if (!wdog_armed) since_arm <= '0;
      end else if (step) begin
        wdog_count <= wdog_count - 7'h01;
      end
      if (wdog_armed && step && since_arm != 7'h7f) since_arm <= since_arm + 7'h01;
    end
  end

  // instr_cnt counts instructions modulo 4, readable in bits 7:6 of the core status register
  always_ff @(posedge i_mclk) begin
    if (int_reset) instr_cnt <= '0;
    else if (step) instr_cnt <= instr_cnt + 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt sources and vectors

  logic pa_prev;
  logic pb_prev;
  logic nmi_prev;
  logic pa_pend;
  logic pb_pend;
  logic nmi_pend;

  wire pa_edge  = pa_lvl && !pa_prev;
  wire pb_edge  = source2_polarity ? (pb_lvl && !pb_prev) : (!pb_lvl && pb_prev);
  wire pa_req   = source1_level_mode ? pa_lvl : pa_pend;
  wire tmr_req  = i_timer_zero_flag && i_timer_irq_mask;
  wire adc_req  = i_adc_done_flag && i_adc_irq_mask;
  wire mask_req = interrupts_allowed && (pa_req || pb_pend || tmr_req || adc_req);
  wire any_req  = nmi_pend || mask_req;

  logic [2:0] next_vec;
  assign next_vec = nmi_pend ? sysctl_pkg::VEC_NMI :
                    pa_req   ? sysctl_pkg::VEC_PORT_A :
                    pb_pend  ? sysctl_pkg::VEC_PORT_B :
                    tmr_req  ? sysctl_pkg::VEC_TIMER : sysctl_pkg::VEC_ADC;

  logic [2:0] cur_vec;
  wire        clr_now = i_irq_taken;

  // Set wins over clear when an edge arrives with the acknowledge
  always_ff @(posedge i_mclk) begin
    if (int_reset) begin
      pa_prev  <= 1'b0;
      pb_prev  <= 1'b0;
      nmi_prev <= 1'b0;
      pa_pend  <= 1'b0;
      pb_pend  <= 1'b0;
      nmi_pend <= 1'b0;
    end else begin
      pa_prev  <= pa_lvl;
      pb_prev  <= pb_lvl;
      nmi_prev <= nmi_low;
      // The taken source is the one selected now, not the previous one in cur_vec
      pa_pend  <= pa_edge || (pa_pend && !(clr_now && next_vec == sysctl_pkg::VEC_PORT_A));
      pb_pend  <= pb_edge || (pb_pend && !(clr_now && next_vec == sysctl_pkg::VEC_PORT_B));
      nmi_pend <= (nmi_low && !nmi_prev)
                  || (nmi_pend && !(clr_now && next_vec == sysctl_pkg::VEC_NMI));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag sets, inhibit, clearing-load anomaly

  sysctl_pkg::flag_set_e flag_set;
  sysctl_pkg::flag_set_e flag_prev;
  logic                  in_irq;
  logic [1:0]            ldi_cycle;
  wire                   ldi_hazard = i_ldi_clear_ior && ldi_cycle < 2'(sysctl_pkg::LDI_WINDOW);
  wire                   inhibited  = in_irq && !nmi_pend;

  always_ff @(posedge i_mclk) begin
    if (int_reset || !i_ldi_clear_ior) ldi_cycle <= '0;
    else if (ldi_cycle != 2'(sysctl_pkg::LDI_CYCLES - 1)) ldi_cycle <= ldi_cycle + 2'h1;
  end

  always_ff @(posedge i_mclk) begin
    if (int_reset) begin
      flag_set  <= sysctl_pkg::FLAGS_NMI;
      flag_prev <= sysctl_pkg::FLAGS_NORMAL;
      in_irq    <= 1'b1;
      cur_vec   <= sysctl_pkg::VEC_NMI;
    end else if (i_irq_taken) begin
      flag_prev <= flag_set;
      in_irq    <= 1'b1;
      cur_vec   <= next_vec;
      if (next_vec == sysctl_pkg::VEC_NMI) flag_set <= sysctl_pkg::FLAGS_NMI;
      else if (!(ldi_hazard && flag_set == sysctl_pkg::FLAGS_NORMAL))
        flag_set <= sysctl_pkg::FLAGS_IRQ;
    end else if (i_return_from_interrupt) begin
      flag_set  <= flag_prev;
      in_irq    <= (flag_prev != sysctl_pkg::FLAGS_NORMAL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Return stack: six levels, oldest lost on overflow, pop of empty holds

  logic [PC_WIDTH_P-1:0] stack [sysctl_pkg::STACK_DEPTH];
  logic [2:0]            depth;

  always_ff @(posedge i_mclk) begin
    if (int_reset) begin
      depth <= '0;
    end else if (i_irq_taken) begin
      for (int k = sysctl_pkg::STACK_DEPTH - 1; k > 0; k--) stack[k] <= stack[k - 1];
      stack[0] <= i_pc;
      if (depth != 3'(sysctl_pkg::STACK_DEPTH)) depth <= depth + 3'h1;
    end else if (i_return_from_interrupt && depth != 3'h0) begin
      for (int k = 0; k < sysctl_pkg::STACK_DEPTH - 1; k++) stack[k] <= stack[k + 1];
      depth <= depth - 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and read data

  wire [7:0] status = {instr_cnt, 1'b0, depth, in_irq, wdog_armed};
  wire [7:0] rd_mux = (i_haddr[7:0] == sysctl_pkg::ADDR_WDOG)        ? watchdog_register :
                      (i_haddr[7:0] == sysctl_pkg::ADDR_CORE_STATUS) ? status :
                      (i_haddr[7:0] == sysctl_pkg::ADDR_CORE_CTRL)   ? {6'h00, flag_set} : 8'h00;

  always_ff @(posedge i_mclk) begin
    if (int_reset) begin
      o_hrdata      <= '0;
      o_irq_request <= 1'b0;
      o_vector_pc   <= '0;
      o_return_pc   <= '0;
      o_wake        <= 1'b0;
      o_flag_set    <= '0;
    end else begin
      if (rd_cycle) o_hrdata <= {24'h000000, rd_mux};
      o_irq_request <= any_req && !inhibited && !i_irq_taken;
      o_vector_pc   <= VECTOR_BASE + PC_WIDTH_P'(next_vec);
      o_return_pc   <= stack[0];
      o_wake        <= (i_stop_mode || i_wait_mode) && (mask_req
                       || (nmi_pend && interrupts_allowed));
      o_flag_set    <= flag_set;
    end
  end

  always_ff @(posedge i_mclk) begin
    o_hreadyout <= 1'b1;
    o_hresp     <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_arm_write;
    wr_wdog && i_hwdata[sysctl_pkg::BIT_ARM];
  endsequence

  arm_sticky_a: assert property (@(posedge i_mclk) disable iff (int_reset)
    s_arm_write |=> wdog_armed[*8]) else $error("arm bit dropped");
  soft_kill_a: assert property (@(posedge i_mclk) disable iff (int_reset)
    soft_kill |=> wdog_fire) else $error("soft reset missed");
  early_fire_a: assert property (@(posedge i_mclk) disable iff (int_reset)
    wdog_fire && !$past(soft_kill) |-> $past(since_arm) >= sysctl_pkg::WDOG_MIN_COUNT)
    else $error("watchdog too early");
  nmi_flags_a: assert property (@(posedge i_mclk)
    $fell(int_reset) |-> flag_set == sysctl_pkg::FLAGS_NMI) else $error("not NMI flags");
  stack_cap_a: assert property (@(posedge i_mclk) disable iff (int_reset)
    depth <= 3'h6) else $error("stack too deep");
  ior_clear_a: assert property (@(posedge i_mclk)
    int_reset |=> irq_config_register == 8'h00) else $error("option not cleared");
  pin_reset_a: assert property (@(posedge i_mclk)
    pin_low |=> ##1 o_reset) else $error("pin reset missed");
  return_from_interrupt_flags_a: assert property (@(posedge i_mclk) disable iff (int_reset)
    i_return_from_interrupt && !i_irq_taken |=> flag_set == $past(flag_prev))
    else $error("flags not restored");

endmodule : sysctl

// File: sysctl_pkg.sv
// Package for the reset, watchdog and interrupt control block.
// Assumes a 10 MHz core clock and an AHB-Lite register slave.
package sysctl_pkg;

  localparam logic [7:0] ADDR_IRQ_OPTION   = 8'hc8;
  localparam logic [7:0] ADDR_WDOG         = 8'hd8;
  localparam logic [7:0] ADDR_CORE_CTRL    = 8'he0;
  localparam logic [7:0] ADDR_CORE_STATUS  = 8'he4;
  localparam logic [7:0] ADDR_STACK_TOP    = 8'he8;

  localparam logic [7:0] IRQ_OPTION_RESET  = 8'h00;
  localparam logic [7:0] WDOG_RESET        = 8'hfe;
  localparam int         BIT_ARM           = 0;
  localparam int         BIT_SOFT_RESET_N  = 1;
  localparam int         BIT_GLOBAL_EN     = 4;
  localparam int         BIT_SRC2_POL      = 5;
  localparam int         BIT_SRC1_LEVEL    = 6;

  localparam int         STACK_DEPTH       = 6;
  localparam int         PC_WIDTH          = 12;
  localparam int         VEC_NUM           = 5;

  // Vector index per source; vector 0 is the NMI
  localparam logic [2:0] VEC_NMI           = 3'h0;
  localparam logic [2:0] VEC_PORT_A        = 3'h1;
  localparam logic [2:0] VEC_PORT_B        = 3'h2;
  localparam logic [2:0] VEC_TIMER         = 3'h3;
  localparam logic [2:0] VEC_ADC           = 3'h4;

  // Watchdog counts one step per instruction (4 cycles of 100 ns)
  localparam int         CLK_PERIOD_NS     = 100;
  localparam int         INSTR_TIME_NS     = 400;
  localparam int         INSTR_CYCLES      = INSTR_TIME_NS / CLK_PERIOD_NS;
  localparam logic [6:0] WDOG_MIN_COUNT    = 7'h1c;
  localparam int         LDI_CYCLES        = 4;
  localparam int         LDI_WINDOW        = 3;

  typedef enum logic [1:0] {FLAGS_NORMAL, FLAGS_IRQ, FLAGS_NMI} flag_set_e;

  typedef struct packed {
    logic htrans1;
    logic hwrite;
    logic [7:0] haddr;
  } bus_req_s;

endpackage : sysctl_pkg

// File: reset_stretch.sv
// Reset stretcher: holds the internal reset for a cycle count after the cause ends.
// Assumes the cause input is already synchronous to i_mclk.
`timescale 1ns/1ps
module reset_stretch #(
  parameter int STRETCH_CYCLES = 4096
) (
  input  wire logic i_mclk,
  input  wire logic i_cause,
  output logic      o_reset
);

  logic [15:0] count;
  wire         expired = (count == 16'h0000);

  // Cause reloads the counter; counting starts only once it has gone
  always_ff @(posedge i_mclk) begin
    if (i_cause) begin
      count <= 16'(STRETCH_CYCLES);
    end else if (!expired) begin
      count <= count - 16'h0001;
    end
  end

  always_ff @(posedge i_mclk) begin
    o_reset <= i_cause || !expired;
  end

endmodule : reset_stretch

// File: core_model.sv
// Stand-in for the processor core: steps instructions, takes interrupts, returns.
// Assumes it shares i_mclk with sysctl and is held by its internal reset.
`timescale 1ns/1ps
module core_model #(
  parameter int STEP_CYCLES = sysctl_pkg::INSTR_CYCLES
) (
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic [7:0]  i_steps,
  input  wire logic        i_go,
  input  wire logic        i_irq_request,
  input  wire logic        i_accept,
  input  wire logic        i_ret,
  output logic             o_busy,
  output logic             o_instr_done,
  output logic             o_irq_taken,
  output logic             o_return,
  output logic [11:0]      o_pc
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] left;
  logic [2:0] phase;
  logic       serving;

  assign o_busy = (left != 8'h00) || i_go;

  always_ff @(posedge i_mclk) begin
    o_instr_done <= 1'h0;
    o_irq_taken  <= 1'h0;
    o_return     <= 1'h0;
    if (i_reset) begin
      left    <= 8'h00;
      phase   <= 3'h0;
      serving <= 1'h0;
      o_pc    <= 12'h000;
    end else begin
      if (i_go) begin
        left  <= i_steps;
        phase <= 3'h0;
      end else if (left != 8'h00) begin
        if (phase == 3'(STEP_CYCLES - 1)) begin
          phase        <= 3'h0;
          left         <= left - 8'h01;
          o_instr_done <= 1'h1;
          o_pc         <= o_pc + 12'h001;
        end else begin
          phase <= phase + 3'h1;
        end
      end
      // No second entry before the return of the first
      if (i_accept && i_irq_request && !serving) begin
        o_irq_taken <= 1'h1;
        serving     <= 1'h1;
      end
      if (i_ret) begin
        o_return <= 1'h1;
        serving  <= 1'h0;
      end
    end
  end
endmodule : core_model

// File: reset_watchdog_irq_control_tb_top.sv
// Bench for sysctl: reset causes, watchdog register, option register, interrupt flow.
// Assumes core_model as the core and a 10 MHz clock; the stretch is shortened.
`timescale 1ns/1ps
module reset_watchdog_irq_control_tb_top;
  localparam int          SC = 8;
  localparam logic [11:0] VB = 12'hff0;
  localparam logic [7:0]  WD = sysctl_pkg::ADDR_WDOG;
  localparam logic [7:0]  OP = sysctl_pkg::ADDR_IRQ_OPTION;
  logic        i_mclk = 1'h0, i_reset = 1'h1, i_hsel = 1'h0, i_hwrite = 1'h0;
  logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0;
  logic [1:0]  i_htrans = 2'h0;
  logic [2:0]  i_hsize = 3'h2;
  logic        i_reset_pin_n = 1'h1, i_power_on = 1'h0, i_low_voltage_detect = 1'h0;
  logic        i_stop_mode = 1'h0, i_wait_mode = 1'h0, i_nmi_n = 1'h1;
  logic        i_port_a_irq = 1'h0, i_port_b_irq = 1'h0;
  logic        i_timer_zero_flag = 1'h0, i_timer_irq_mask = 1'h0;
  logic        i_adc_done_flag = 1'h0, i_adc_irq_mask = 1'h0;
  logic        go = 1'h0, accept = 1'h0, ret = 1'h0;
  logic [7:0]  steps = 8'h00;
  logic [31:0] o_hrdata;
  logic        o_hreadyout, o_hresp, o_reset, o_io_pullup_inputs, o_osc_restart;
  logic        o_irq_request, o_wake, busy, idone, taken, creturn;
  logic [11:0] o_vector_pc, o_return_pc, pc;
  logic [1:0]  o_flag_set;
  int          num_errors = 0, tests_run = 0;

  always #50 i_mclk = ~i_mclk;

  sysctl #(.STRETCH_CYCLES(SC), .VECTOR_BASE(VB)) i_sysctl (
    .i_mclk, .i_reset, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
    .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .i_reset_pin_n,
    .i_power_on, .i_low_voltage_detect, .i_stop_mode, .i_wait_mode,
    .i_instr_done(idone), .i_ldi_clear_ior(1'h0), .i_nmi_n, .i_port_a_irq,
    .i_port_b_irq, .i_timer_zero_flag, .i_timer_irq_mask, .i_adc_done_flag,
    .i_adc_irq_mask, .i_irq_taken(taken), .i_return_from_interrupt(creturn), .i_pc(pc),
    .o_reset, .o_io_pullup_inputs, .o_osc_restart, .o_irq_request, .o_vector_pc,
    .o_return_pc, .o_wake, .o_flag_set);

  core_model i_core_model (
    .i_mclk, .i_reset(o_reset), .i_steps(steps), .i_go(go), .i_irq_request(o_irq_request),
    .i_accept(accept), .i_ret(ret), .o_busy(busy), .o_instr_done(idone),
    .o_irq_taken(taken), .o_return(creturn), .o_pc(pc));

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (num_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic pick(input int w);
    case (w)
      0: return o_reset;
      1: return o_irq_request;
      2: return taken;
      default: return busy;
    endcase
  endfunction : pick

  task automatic wait_for(input int w, input logic lvl, output int n);
    for (n = 0; n < 2000 && pick(w) !== lvl; n++) @(posedge i_mclk);
    if (n >= 2000) begin
      num_errors++;
      $display("wrong value at %0t: wait ran out", $time);
      summarize();
    end
  endtask : wait_for

  // Single word transfer; the address phase is held until hready is seen high
  task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] wd,
                     output logic [7:0] rd);
    int n;
    n = 0;
    i_hsel   <= 1'h1;
    i_haddr  <= {24'h000000, a};
    i_htrans <= 2'h2;
    i_hwrite <= w;
    do begin @(posedge i_mclk); n++; end while (o_hreadyout !== 1'h1 && n < 500);
    i_hsel   <= 1'h0;
    i_htrans <= 2'h0;
    i_hwdata <= {24'h000000, wd};
    do begin @(posedge i_mclk); n++; end while (o_hreadyout !== 1'h1 && n < 500);
    rd = o_hrdata[7:0];
    check(o_hresp, 1'h0);
    if (n >= 500) begin
      num_errors++;
      $display("wrong value at %0t: bus wait ran out", $time);
      summarize();
    end
  endtask : ahb

  task automatic run(input logic [7:0] k, output logic hit);
    int n;
    hit = 1'h0;
    steps <= k;
    go <= 1'h1;
    @(posedge i_mclk);
    go <= 1'h0;
    for (n = 0; n < 2000 && busy === 1'h1; n++) begin
      @(posedge i_mclk);
      if (o_reset !== 1'h0) hit = 1'h1;
    end
  endtask : run

  task automatic settle();
    int n;
    logic [7:0] rd;
    wait_for(0, 1'h0, n);
    ahb(1'h0, WD, 8'h00, rd);
    check(rd, sysctl_pkg::WDOG_RESET);
    check(o_flag_set, 2'h2);
  endtask : settle

  task automatic reset_causes();
    int n, m;
    for (int k = 0; k < 5; k++) begin
      i_reset_pin_n <= (k > 2);
      i_stop_mode <= (k == 2);
      i_power_on <= (k == 3);
      i_low_voltage_detect <= (k == 4);
      repeat ((k == 1) ? 3 : 20) @(posedge i_mclk);
      if (k != 1) check(o_reset, 1'h1);
      if (k != 1) check(o_io_pullup_inputs, 1'h1);
      if (k == 0 || k == 2) check(o_osc_restart, 1'h1);
      i_reset_pin_n <= 1'h1;
      i_stop_mode <= 1'h0;
      i_power_on <= 1'h0;
      i_low_voltage_detect <= 1'h0;
      wait_for(0, 1'h1, n);
      wait_for(0, 1'h0, m);
      check(n + m >= SC && n + m <= SC + 8, 1'h1);
      settle();
    end
  endtask : reset_causes

  task automatic wdog_tests();
    logic [7:0] rd;
    logic hit;
    int n;
    ahb(1'h1, WD, 8'ha2, rd); // Count 7'h45, soft reset bit as its top bit
    run(8'h06, hit);
    check(hit, 1'h0);
    ahb(1'h0, WD, 8'h00, rd);
    check(rd, 8'hfc);
    ahb(1'h1, WD, 8'h83, rd);
    ahb(1'h1, WD, 8'h82, rd);
    ahb(1'h0, WD, 8'h00, rd);
    check(rd[0], 1'h1);
    run(8'h1b, hit);
    check(hit, 1'h0);
    run(8'h64, hit);
    check(hit, 1'h1);
    settle();
    ahb(1'h1, WD, 8'hff, rd);
    ahb(1'h1, WD, 8'hfd, rd);
    wait_for(0, 1'h1, n);
    check(n < 10, 1'h1);
    settle();
  endtask : wdog_tests

  task automatic serve(input logic [2:0] v, input logic [1:0] f);
    int n;
    wait_for(1, 1'h1, n);
    check(o_vector_pc, VB + 12'(v));
    accept <= 1'h1;
    wait_for(2, 1'h1, n);
    accept <= 1'h0;
    repeat (3) @(posedge i_mclk);
    check(o_flag_set, f);
    check(o_return_pc, pc);
  endtask : serve

  task automatic back();
    ret <= 1'h1;
    @(posedge i_mclk);
    ret <= 1'h0;
    repeat (3) @(posedge i_mclk);
    check(o_flag_set, 2'h0);
  endtask : back

  task automatic irq_tests();
    logic [7:0] rd;
    back();
    i_timer_zero_flag <= 1'h1;
    i_timer_irq_mask <= 1'h1;
    repeat (4) @(posedge i_mclk);
    check(o_irq_request, 1'h0);
    ahb(1'h1, OP, 8'h10, rd);
    i_timer_irq_mask <= 1'h0;
    repeat (4) @(posedge i_mclk);
    check(o_irq_request, 1'h0);
    i_timer_irq_mask <= 1'h1;
    serve(3'h3, 2'h1);
    i_timer_zero_flag <= 1'h0;
    back();
    i_adc_done_flag <= 1'h1;
    i_adc_irq_mask <= 1'h1;
    serve(3'h4, 2'h1);
    i_adc_done_flag <= 1'h0;
    back();
    i_port_a_irq <= 1'h1;
    serve(3'h1, 2'h1);
    back();
    repeat (3) @(posedge i_mclk);
    check(o_irq_request, 1'h0);
    ahb(1'h1, OP, 8'h50, rd);
    serve(3'h1, 2'h1);
    i_port_a_irq <= 1'h0;
    back();
    ahb(1'h1, OP, 8'h30, rd);
    i_port_b_irq <= 1'h1;
    serve(3'h2, 2'h1);
    i_port_b_irq <= 1'h0;
    back();
    repeat (3) @(posedge i_mclk);
    check(o_irq_request, 1'h0);
    i_wait_mode <= 1'h1;
    i_timer_zero_flag <= 1'h1;
    repeat (3) @(posedge i_mclk);
    check(o_wake, 1'h1);
    i_timer_zero_flag <= 1'h0;
    ahb(1'h1, OP, 8'h00, rd);
    i_nmi_n <= 1'h0;
    serve(3'h0, 2'h2);
    check(o_wake, 1'h0);
    i_nmi_n <= 1'h1;
    i_wait_mode <= 1'h0;
    back();
  endtask : irq_tests

  initial begin
    logic [7:0] rd;
    repeat (16) @(posedge i_mclk);
    i_reset <= 1'h0;
    settle();
    ahb(1'h1, OP, 8'h10, rd);
    ahb(1'h0, OP, 8'h00, rd);
    check(rd, 8'h00);
    ahb(1'h1, 8'h40, 8'h5a, rd);
    ahb(1'h0, 8'h40, 8'h00, rd);
    check(rd, 8'h00);
    reset_causes();
    wdog_tests();
    irq_tests();
    summarize();
  end
endmodule : reset_watchdog_irq_control_tb_top
